// ### inc/btpm_pkg.sv
// Package for the Bluetooth pad function multiplexer
package btpm_pkg;
  // APB register map, byte addresses
  localparam logic [7:0] SEL_LO_OFS   = 8'h00;
  localparam logic [7:0] SEL_HI_OFS   = 8'h04;
  localparam logic [7:0] GPIO_OUT_OFS = 8'h08;
  localparam logic [7:0] GPIO_OE_OFS  = 8'h0C;
  localparam logic [7:0] GPIO_IN_OFS  = 8'h10;
  localparam logic [7:0] AGPIO_OUT_OFS = 8'h14;
  localparam logic [7:0] AGPIO_OE_OFS  = 8'h18;
  localparam logic [7:0] AGPIO_IN_OFS  = 8'h1C;
  localparam logic [7:0] CORE_IN_OFS   = 8'h20;
  // Pad count and select layout
  localparam int NPAD     = 19;
  localparam int SEL_W    = 3;
  localparam int PADS_LO  = 10;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
  localparam logic [7:0] GP_RST = 8'h00;

  // Pad indices
  localparam int P_CTS = 0;
  localparam int P_RTS = 1;
  localparam int P_RXD = 2;
  localparam int P_TXD = 3;
  localparam int P_PIN = 4;
  localparam int P_POUT = 5;
  localparam int P_PSYNC = 6;
  localparam int P_PCLK = 7;
  localparam int P_SDO = 8;
  localparam int P_SDI = 9;
  localparam int P_SWS = 10;
  localparam int P_SCLK = 11;
  localparam int P_G5 = 12;
  localparam int P_G4 = 13;
  localparam int P_G3 = 14;
  localparam int P_G2 = 15;
  localparam int P_G1 = 16;
  localparam int P_G0 = 17;
  localparam int P_CREQ = 18;

  // Signals coming from the core peripherals
  typedef struct packed {
    logic uart_rts;
    logic uart_txd;
    logic pcm_out;
    logic pcm_sync;
    logic pcm_clk;
    logic pcm_master;
    logic host_clock;
    logic link_activity;
    logic coex_activity;
    logic internal_low_power_clock;
    logic sound_master_data_out;
    logic sound_master_word_select;
    logic sound_master_clock;
    logic sound_slave_data_out;
    logic priority_status;
    logic audio_ref_clock_out;
    logic power_class_ctrl_bit2;
    logic combined_clock_request;
  } btpm_core_out_t;

  // Signals returned to the core peripherals
  typedef struct packed {
    logic uart_cts;
    logic uart_rxd;
    logic pcm_in;
    logic pcm_sync;
    logic pcm_clk;
    logic sound_slave_clock;
    logic sound_slave_word_select;
    logic sound_data_input;
    logic coex_transmit_grant;
  } btpm_core_in_t;
endpackage : btpm_pkg

// ### rtl/btpm_mux.sv
// Per-pad function multiplexer with APB select and GPIO registers
`timescale 1ns/1ps
`default_nettype none

module btpm_mux (
  input  wire logic                   CLK_I,
  input  wire logic                   RSTN_I,
  input  wire logic                   PSEL_I,
  input  wire logic                   PENABLE_I,
  input  wire logic                   PWRITE_I,
  input  wire logic [7:0]             PADDR_I,
  input  wire logic [31:0]            PWDATA_I,
  output logic      [31:0]            PRDATA_O,
  output logic                        PREADY_O,
  output logic                        PSLVERR_O,
  input  wire btpm_pkg::btpm_core_out_t CORE_I,
  output btpm_pkg::btpm_core_in_t     CORE_O,
  output logic                        COEX_ACTIVITY_O,
  input  wire logic [btpm_pkg::NPAD-1:0] PAD_I,
  output logic      [btpm_pkg::NPAD-1:0] PAD_O,
  output logic      [btpm_pkg::NPAD-1:0] PAD_OE_N_O
);
  import btpm_pkg::*;

  logic [SEL_W-1:0] sel_ff [NPAD];
  logic [7:0]       gp_out_ff;
  logic [7:0]       gp_oe_ff;
  logic [7:0]       ag_out_ff;
  logic [7:0]       ag_oe_ff;
  logic [7:0]       gp_in_ff;
  logic [7:0]       ag_in_ff;
  logic [7:0]       nxt_gp_in;
  logic [7:0]       nxt_ag_in;
  logic [NPAD-1:0]  nxt_pad_o;
  logic [NPAD-1:0]  nxt_pad_drv;
  btpm_core_in_t    nxt_core;
  logic [31:0]      rdata;
  logic             wr_en;
  logic             rd_en;
  logic             hit;

  // One-cycle access phase, write takes effect at the pready edge
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  // Select registers, one three-bit field per pad
  genvar gi;
  generate
    for (gi = 0; gi < NPAD; gi++)
    begin : g_sel
      always_ff @(posedge CLK_I)
      begin
        if (!RSTN_I)
          sel_ff[gi] <= SEL_RST;
        else if (wr_en && gi < PADS_LO && PADDR_I == SEL_LO_OFS)
          sel_ff[gi] <= PWDATA_I[(gi%PADS_LO)*SEL_W +: SEL_W];
        else if (wr_en && gi >= PADS_LO && PADDR_I == SEL_HI_OFS)
          sel_ff[gi] <= PWDATA_I[(gi%PADS_LO)*SEL_W +: SEL_W];
      end
    end
  endgenerate

  // GPIO output and direction registers for both groups
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      gp_out_ff <= GP_RST;
      gp_oe_ff  <= GP_RST;
      ag_out_ff <= GP_RST;
      ag_oe_ff  <= GP_RST;
    end
    else if (wr_en)
    begin
      case (PADDR_I)
        GPIO_OUT_OFS:  gp_out_ff <= PWDATA_I[7:0];
        GPIO_OE_OFS:   gp_oe_ff  <= PWDATA_I[7:0];
        AGPIO_OUT_OFS: ag_out_ff <= PWDATA_I[7:0];
        AGPIO_OE_OFS:  ag_oe_ff  <= PWDATA_I[7:0];
        default:       ;
      endcase
    end
  end

  // Pad multiplexing; a case or if on each pad's select field picks its matrix entry, general pads 5..0 taking setting 0 from a shared loop
  always_comb
  begin
    nxt_pad_o   = '0;
    nxt_pad_drv = '0;
    nxt_gp_in   = '0;
    nxt_ag_in   = '0;
    nxt_core    = '0;
    // Host UART pads
    case (sel_ff[P_CTS])
      3'h0: nxt_core.uart_cts = PAD_I[P_CTS];
      3'h7:
      begin
        nxt_ag_in[1] = PAD_I[P_CTS];
        nxt_pad_o[P_CTS] = ag_out_ff[1];
        nxt_pad_drv[P_CTS] = ag_oe_ff[1];
      end
      default: ;
    endcase
    case (sel_ff[P_RTS])
      3'h0:
      begin
        nxt_pad_o[P_RTS] = CORE_I.uart_rts;
        nxt_pad_drv[P_RTS] = 1'b1;
      end
      3'h7:
      begin
        nxt_ag_in[0] = PAD_I[P_RTS];
        nxt_pad_o[P_RTS] = ag_out_ff[0];
        nxt_pad_drv[P_RTS] = ag_oe_ff[0];
      end
      default: ;
    endcase
    case (sel_ff[P_RXD])
      3'h0: nxt_core.uart_rxd = PAD_I[P_RXD];
      3'h7:
      begin
        nxt_gp_in[5] = PAD_I[P_RXD];
        nxt_pad_o[P_RXD] = gp_out_ff[5];
        nxt_pad_drv[P_RXD] = gp_oe_ff[5];
      end
      default: ;
    endcase
    case (sel_ff[P_TXD])
      3'h0:
      begin
        nxt_pad_o[P_TXD] = CORE_I.uart_txd;
        nxt_pad_drv[P_TXD] = 1'b1;
      end
      3'h7:
      begin
        nxt_gp_in[4] = PAD_I[P_TXD];
        nxt_pad_o[P_TXD] = gp_out_ff[4];
        nxt_pad_drv[P_TXD] = gp_oe_ff[4];
      end
      default: ;
    endcase
    // PCM pads
    case (sel_ff[P_PIN])
      3'h0:
      begin
        nxt_ag_in[3] = PAD_I[P_PIN];
        nxt_pad_o[P_PIN] = ag_out_ff[3];
        nxt_pad_drv[P_PIN] = ag_oe_ff[3];
      end
      3'h1, 3'h2: nxt_core.pcm_in = PAD_I[P_PIN];
      3'h3:
      begin
        nxt_pad_o[P_PIN] = CORE_I.host_clock;
        nxt_pad_drv[P_PIN] = 1'b1;
      end
      3'h7: nxt_core.sound_data_input = PAD_I[P_PIN];
      default: ;
    endcase
    case (sel_ff[P_POUT])
      3'h0:
      begin
        nxt_ag_in[2] = PAD_I[P_POUT];
        nxt_pad_o[P_POUT] = ag_out_ff[2];
        nxt_pad_drv[P_POUT] = ag_oe_ff[2];
      end
      3'h1, 3'h2:
      begin
        nxt_pad_o[P_POUT] = CORE_I.pcm_out;
        nxt_pad_drv[P_POUT] = 1'b1;
      end
      3'h3:
      begin
        nxt_pad_o[P_POUT] = CORE_I.link_activity;
        nxt_pad_drv[P_POUT] = 1'b1;
      end
      3'h5:
      begin
        nxt_pad_o[P_POUT] = CORE_I.sound_master_data_out;
        nxt_pad_drv[P_POUT] = 1'b1;
      end
      3'h7:
      begin
        nxt_pad_o[P_POUT] = CORE_I.sound_slave_data_out;
        nxt_pad_drv[P_POUT] = 1'b1;
      end
      default: ;
    endcase
    case (sel_ff[P_PSYNC])
      3'h0:
      begin
        nxt_ag_in[1] = nxt_ag_in[1] | PAD_I[P_PSYNC];
        nxt_pad_o[P_PSYNC] = ag_out_ff[1];
        nxt_pad_drv[P_PSYNC] = ag_oe_ff[1];
      end
      3'h1, 3'h2:
      begin
        nxt_core.pcm_sync = PAD_I[P_PSYNC];
        nxt_pad_o[P_PSYNC] = CORE_I.pcm_sync;
        nxt_pad_drv[P_PSYNC] = CORE_I.pcm_master;
      end
      3'h3:
      begin
        nxt_pad_o[P_PSYNC] = CORE_I.host_clock;
        nxt_pad_drv[P_PSYNC] = 1'b1;
      end
      3'h4:
      begin
        nxt_pad_o[P_PSYNC] = CORE_I.internal_low_power_clock;
        nxt_pad_drv[P_PSYNC] = 1'b1;
      end
      3'h5:
      begin
        nxt_pad_o[P_PSYNC] = CORE_I.sound_master_word_select;
        nxt_pad_drv[P_PSYNC] = 1'b1;
      end
      3'h7: nxt_core.sound_slave_word_select = PAD_I[P_PSYNC];
      default: ;
    endcase
    case (sel_ff[P_PCLK])
      3'h0:
      begin
        nxt_ag_in[0] = nxt_ag_in[0] | PAD_I[P_PCLK];
        nxt_pad_o[P_PCLK] = ag_out_ff[0];
        nxt_pad_drv[P_PCLK] = ag_oe_ff[0];
      end
      3'h1, 3'h2:
      begin
        nxt_core.pcm_clk = PAD_I[P_PCLK];
        nxt_pad_o[P_PCLK] = CORE_I.pcm_clk;
        nxt_pad_drv[P_PCLK] = CORE_I.pcm_master;
      end
      3'h5:
      begin
        nxt_pad_o[P_PCLK] = CORE_I.sound_master_clock;
        nxt_pad_drv[P_PCLK] = 1'b1;
      end
      3'h7: nxt_core.sound_slave_clock = PAD_I[P_PCLK];
      default: ;
    endcase
    // Sound-bus pads
    case (sel_ff[P_SDO])
      3'h0:
      begin
        nxt_ag_in[5] = PAD_I[P_SDO];
        nxt_pad_o[P_SDO] = ag_out_ff[5];
        nxt_pad_drv[P_SDO] = ag_oe_ff[5];
      end
      3'h1:
      begin
        nxt_pad_o[P_SDO] = CORE_I.pcm_out;
        nxt_pad_drv[P_SDO] = 1'b1;
      end
      3'h4:
      begin
        nxt_pad_o[P_SDO] = CORE_I.sound_slave_data_out;
        nxt_pad_drv[P_SDO] = 1'b1;
      end
      3'h5:
      begin
        nxt_pad_o[P_SDO] = CORE_I.sound_master_data_out;
        nxt_pad_drv[P_SDO] = 1'b1;
      end
      3'h7:
      begin
        nxt_pad_o[P_SDO] = CORE_I.priority_status;
        nxt_pad_drv[P_SDO] = 1'b1;
      end
      default: ;
    endcase
    case (sel_ff[P_SDI])
      3'h0:
      begin
        nxt_ag_in[6] = PAD_I[P_SDI];
        nxt_pad_o[P_SDI] = ag_out_ff[6];
        nxt_pad_drv[P_SDI] = ag_oe_ff[6];
      end
      3'h1: nxt_core.pcm_in = nxt_core.pcm_in | PAD_I[P_SDI];
      3'h3:
      begin
        nxt_pad_o[P_SDI] = CORE_I.host_clock;
        nxt_pad_drv[P_SDI] = 1'b1;
      end
      3'h4: nxt_core.sound_data_input =
              nxt_core.sound_data_input | PAD_I[P_SDI];
      3'h7: nxt_core.coex_transmit_grant = PAD_I[P_SDI];
      default: ;
    endcase
    case (sel_ff[P_SWS])
      3'h0:
      begin
        nxt_gp_in[7] = PAD_I[P_SWS];
        nxt_pad_o[P_SWS] = gp_out_ff[7];
        nxt_pad_drv[P_SWS] = gp_oe_ff[7];
      end
      3'h1:
      begin
        nxt_core.pcm_sync = nxt_core.pcm_sync | PAD_I[P_SWS];
        nxt_pad_o[P_SWS] = CORE_I.pcm_sync;
        nxt_pad_drv[P_SWS] = CORE_I.pcm_master;
      end
      3'h3:
      begin
        nxt_pad_o[P_SWS] = CORE_I.link_activity;
        nxt_pad_drv[P_SWS] = 1'b1;
      end
      3'h5:
      begin
        nxt_pad_o[P_SWS] = CORE_I.sound_master_word_select;
        nxt_pad_drv[P_SWS] = 1'b1;
      end
      3'h7: nxt_core.sound_slave_word_select =
              nxt_core.sound_slave_word_select | PAD_I[P_SWS];
      default: ;
    endcase
    case (sel_ff[P_SCLK])
      3'h0:
      begin
        nxt_gp_in[6] = PAD_I[P_SCLK];
        nxt_pad_o[P_SCLK] = gp_out_ff[6];
        nxt_pad_drv[P_SCLK] = gp_oe_ff[6];
      end
      3'h1:
      begin
        nxt_core.pcm_clk = nxt_core.pcm_clk | PAD_I[P_SCLK];
        nxt_pad_o[P_SCLK] = CORE_I.pcm_clk;
        nxt_pad_drv[P_SCLK] = CORE_I.pcm_master;
      end
      3'h4:
      begin
        nxt_pad_o[P_SCLK] = CORE_I.internal_low_power_clock;
        nxt_pad_drv[P_SCLK] = 1'b1;
      end
      3'h5:
      begin
        nxt_pad_o[P_SCLK] = CORE_I.sound_master_clock;
        nxt_pad_drv[P_SCLK] = 1'b1;
      end
      3'h7: nxt_core.sound_slave_clock =
              nxt_core.sound_slave_clock | PAD_I[P_SCLK];
      default: ;
    endcase
    // General pads 5..0: setting 0 is the plain GPIO bit
    for (int k = 0; k < 6; k++)
    begin
      if (sel_ff[P_G0 - k] == 3'h0)
      begin
        nxt_gp_in[k] = nxt_gp_in[k] | PAD_I[P_G0 - k];
        nxt_pad_o[P_G0 - k] = gp_out_ff[k];
        nxt_pad_drv[P_G0 - k] = gp_oe_ff[k];
      end
    end
    case (sel_ff[P_G5])
      3'h1: {nxt_pad_o[P_G5], nxt_pad_drv[P_G5]} = {CORE_I.host_clock, 1'b1};
      3'h3: {nxt_pad_o[P_G5], nxt_pad_drv[P_G5]} =
              {CORE_I.sound_master_clock, 1'b1};
      3'h4: nxt_core.sound_slave_clock =
              nxt_core.sound_slave_clock | PAD_I[P_G5];
      3'h7: {nxt_pad_o[P_G5], nxt_pad_drv[P_G5]} =
              {CORE_I.combined_clock_request, 1'b1};
      default: ;
    endcase
    case (sel_ff[P_G4])
      3'h1: {nxt_pad_o[P_G4], nxt_pad_drv[P_G4]} =
              {CORE_I.link_activity, 1'b1};
      3'h3: {nxt_pad_o[P_G4], nxt_pad_drv[P_G4]} =
              {CORE_I.sound_master_data_out, 1'b1};
      3'h4: {nxt_pad_o[P_G4], nxt_pad_drv[P_G4]} =
              {CORE_I.sound_slave_data_out, 1'b1};
      default: ;
    endcase
    case (sel_ff[P_G3])
      3'h3: {nxt_pad_o[P_G3], nxt_pad_drv[P_G3]} =
              {CORE_I.sound_master_word_select, 1'b1};
      3'h4: nxt_core.sound_slave_word_select =
              nxt_core.sound_slave_word_select | PAD_I[P_G3];
      default: ;
    endcase
    if (sel_ff[P_G2] == 3'h4)
      nxt_core.sound_data_input = nxt_core.sound_data_input | PAD_I[P_G2];
    if (sel_ff[P_G1] == 3'h7)
      {nxt_pad_o[P_G1], nxt_pad_drv[P_G1]} =
        {CORE_I.power_class_ctrl_bit2, 1'b1};
    if (sel_ff[P_G0] == 3'h4)
      {nxt_pad_o[P_G0], nxt_pad_drv[P_G0]} =
        {CORE_I.audio_ref_clock_out, 1'b1};
    // Clock request pad
    case (sel_ff[P_CREQ])
      3'h0: {nxt_pad_o[P_CREQ], nxt_pad_drv[P_CREQ]} =
              {CORE_I.combined_clock_request, 1'b1};
      3'h7:
      begin
        nxt_ag_in[7] = PAD_I[P_CREQ];
        nxt_pad_o[P_CREQ] = ag_out_ff[7];
        nxt_pad_drv[P_CREQ] = ag_oe_ff[7];
      end
      default: ;
    endcase
  end

  // Registered pads; costs one cycle of latency on every path
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      PAD_O      <= '0;
      PAD_OE_N_O <= '1;
      CORE_O     <= '0;
      gp_in_ff   <= GP_RST;
      ag_in_ff   <= GP_RST;
    end
    else
    begin
      PAD_O      <= nxt_pad_o;
      PAD_OE_N_O <= ~nxt_pad_drv;
      CORE_O     <= nxt_core;
      gp_in_ff   <= nxt_gp_in;
      ag_in_ff   <= nxt_ag_in;
    end
  end

  // Coex activity has a dedicated output, high during local slots
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      COEX_ACTIVITY_O <= 1'b0;
    else
      COEX_ACTIVITY_O <= CORE_I.coex_activity;
  end

  // Read decode
  always_comb
  begin
    rdata = '0;
    hit   = 1'b1;
    case (PADDR_I)
      SEL_LO_OFS:
        for (int k = 0; k < PADS_LO; k++)
          rdata[k*SEL_W +: SEL_W] = sel_ff[k];
      SEL_HI_OFS:
        for (int k = PADS_LO; k < NPAD; k++)
          rdata[(k-PADS_LO)*SEL_W +: SEL_W] = sel_ff[k];
      GPIO_OUT_OFS:  rdata[7:0] = gp_out_ff;
      GPIO_OE_OFS:   rdata[7:0] = gp_oe_ff;
      GPIO_IN_OFS:   rdata[7:0] = gp_in_ff;
      AGPIO_OUT_OFS: rdata[7:0] = ag_out_ff;
      AGPIO_OE_OFS:  rdata[7:0] = ag_oe_ff;
      AGPIO_IN_OFS:  rdata[7:0] = ag_in_ff;
      CORE_IN_OFS:   rdata[8:0] = CORE_O;
      default:       hit = 1'b0;
    endcase
  end

  // APB answer: ready in the access cycle, error on unmapped address
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      PRDATA_O  <= '0;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~hit;
      if (rd_en)
        PRDATA_O <= rdata;
    end
  end
endmodule : btpm_mux

`default_nettype wire

// ### bench/btpm_far_side.sv
// Far-side model: host, codec and coexistence partner on the pads
`timescale 1ns/1ps
`default_nettype none
module btpm_far_side (
  input  wire logic [btpm_pkg::NPAD-1:0] pad_o_i,
  input  wire logic [btpm_pkg::NPAD-1:0] pad_oe_n_i,
  input  wire logic [btpm_pkg::NPAD-1:0] level_i,
  output logic      [btpm_pkg::NPAD-1:0] pad_i_o
);
  import btpm_pkg::*;
  // Partner drives only pads the device has let go, so no contention;
  // this includes slave sync and clock and the transmit grant pad
  assign pad_i_o = (pad_oe_n_i & level_i) | (~pad_oe_n_i & pad_o_i);
endmodule : btpm_far_side
`default_nettype wire

// ### bench/btpm_mux_props.sv
// Concurrent checks on the pad multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module btpm_mux_props (
  input  wire logic                        CLK_I,
  input  wire logic                        RSTN_I,
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [7:0]                  PADDR_I,
  input  wire logic [31:0]                 PWDATA_I,
  input  wire logic                        PREADY_O,
  input  wire btpm_pkg::btpm_core_out_t    CORE_I,
  input  wire btpm_pkg::btpm_core_in_t     CORE_O,
  input  wire logic                        COEX_ACTIVITY_O,
  input  wire logic [btpm_pkg::NPAD-1:0]   PAD_I,
  input  wire logic [btpm_pkg::NPAD-1:0]   PAD_O,
  input  wire logic [btpm_pkg::NPAD-1:0]   PAD_OE_N_O
);
  import btpm_pkg::*;
  logic [29:0] lo_ff;
  logic [26:0] hi_ff;
  logic        wr_acc;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  // Shadow selects, taken on the same edge the design takes them
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      lo_ff <= '0;
    else if (wr_acc && PADDR_I == SEL_LO_OFS)
      lo_ff <= PWDATA_I[29:0];
  end
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      hi_ff <= '0;
    else if (wr_acc && PADDR_I == SEL_HI_OFS)
      hi_ff <= PWDATA_I[26:0];
  end
  function automatic logic [2:0] sel_of(input int p);
    return (p < PADS_LO) ? lo_ff[3*p +: 3] : hi_ff[3*(p-PADS_LO) +: 3];
  endfunction : sel_of
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence apb_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence apb_access;
    PSEL_I && PENABLE_I && PREADY_O;
  endsequence
  chk_ready_access: assert property (apb_setup |=> apb_access)
    else $error("ready missing in access cycle");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !RSTN_I |=> (&PAD_OE_N_O) && CORE_O == '0)
    else $error("pads or core inputs active after reset");
  chk_uart_rts: assert property (sel_of(P_RTS) == 3'h0 |=>
    !PAD_OE_N_O[P_RTS] && PAD_O[P_RTS] == $past(CORE_I.uart_rts))
    else $error("request-to-send pad wrong");
  chk_cts_input: assert property (sel_of(P_CTS) == 3'h0 |=>
    PAD_OE_N_O[P_CTS] && CORE_O.uart_cts == $past(PAD_I[P_CTS]))
    else $error("clear-to-send not routed");
  chk_clkreq_pad: assert property (sel_of(P_CREQ) == 3'h0 |=>
    PAD_O[P_CREQ] == $past(CORE_I.combined_clock_request))
    else $error("clock request pad wrong");
  chk_audio_clock: assert property (sel_of(P_G0) == 3'h4 |=>
    !PAD_OE_N_O[P_G0] && PAD_O[P_G0] == $past(CORE_I.audio_ref_clock_out))
    else $error("audio clock pad wrong");
  chk_lpo_sync: assert property (sel_of(P_PSYNC) == 3'h4 |=>
    PAD_O[P_PSYNC] == $past(CORE_I.internal_low_power_clock))
    else $error("low-power clock pad wrong");
  chk_pcm_dir: assert property (sel_of(P_PCLK) inside {3'h1, 3'h2} |=>
    PAD_OE_N_O[P_PCLK] == !$past(CORE_I.pcm_master))
    else $error("pcm clock direction wrong");
  chk_empty_undriven: assert property (sel_of(P_G2) != 3'h0 |=>
    PAD_OE_N_O[P_G2])
    else $error("pad driven with no output function");
  chk_grant_input: assert property (sel_of(P_SDI) == 3'h7 |=>
    CORE_O.coex_transmit_grant == $past(PAD_I[P_SDI]))
    else $error("transmit grant not routed");
  chk_coex_copy: assert property ($past(RSTN_I) |->
    COEX_ACTIVITY_O == $past(CORE_I.coex_activity))
    else $error("coex activity output wrong");
  chk_link_pad: assert property (sel_of(P_G4) == 3'h1 |=>
    PAD_O[P_G4] == $past(CORE_I.link_activity))
    else $error("link indicator pad wrong");
endmodule : btpm_mux_props
bind btpm_mux btpm_mux_props btpm_mux_props_i (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PREADY_O(PREADY_O), .CORE_I(CORE_I), .CORE_O(CORE_O),
  .COEX_ACTIVITY_O(COEX_ACTIVITY_O), .PAD_I(PAD_I), .PAD_O(PAD_O),
  .PAD_OE_N_O(PAD_OE_N_O));
`default_nettype wire

// ### bench/btpm_mux_bench.sv
// Self-checking bench for the pad function multiplexer
`timescale 1ns/1ps
`default_nettype none
module btpm_mux_bench;
  import btpm_pkg::*;
  logic            clk, rst_n, psel, pen, pwr, pready, pslverr, err, coex;
  logic [7:0]      paddr, gout, goe, aout, aoe;
  logic [31:0]     pwdata, prdata, rd;
  btpm_core_out_t  core;
  btpm_core_in_t   core_in;
  logic [NPAD-1:0] pad_i, pad_o, pad_oe_n, ext;
  int              sel [NPAD];
  int              mismatches, n_compared, seed;
  // One char per setting: . none, a..r core bit, S/K pcm bidir,
  // 0..7 general bit, A..H second-group bit
  string tbl [NPAD] = '{".......B", "r......A", ".......5", "q......4",
    "D..l....", "Cppk.h.e", "BSSlig..", "AKK..f..", "Fp..eh.d",
    "G..l....", "7S.k.g..", "6K..if..", "5l.f...a", "4k.he...",
    "3..g....", "2.......", "1......b", "0...c...", "a......H"};
  btpm_mux btpm_mux_i (.CLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CORE_I(core), .CORE_O(core_in), .COEX_ACTIVITY_O(coex),
    .PAD_I(pad_i), .PAD_O(pad_o), .PAD_OE_N_O(pad_oe_n));
  btpm_far_side btpm_far_side_i (.pad_o_i(pad_o), .pad_oe_n_i(pad_oe_n),
    .level_i(ext), .pad_i_o(pad_i));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_bit(input logic got, input logic exp, input int p);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t pad %0d got %b exp %b", $time, p, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t word got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word
  // APB master: hold the request until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      mismatches++;
      tally_and_finish();
    end
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  // Write all selects, then read them back
  task automatic put_sel();
    logic [31:0] lo, hi;
    lo = '0;
    hi = '0;
    for (int p = 0; p < NPAD; p++)
      if (p < PADS_LO)
        lo[3*p +: 3] = sel[p][2:0];
      else
        hi[3*(p-PADS_LO) +: 3] = sel[p][2:0];
    apb(1'b1, SEL_LO_OFS, lo);
    apb(1'b1, SEL_HI_OFS, hi);
    apb(1'b0, SEL_LO_OFS, 32'h0);
    cmp_word({2'h0, rd[29:0]}, lo);
    apb(1'b0, SEL_HI_OFS, 32'h0);
    cmp_word({5'h0, rd[26:0]}, hi);
  endtask : put_sel
  // New core levels, partner levels and GPIO registers
  task automatic shake();
    logic [31:0] r, q;
    r = $random(seed);
    q = $random(seed);
    @(posedge clk);
    core <= r[17:0];
    ext  <= q[18:0];
    {gout, goe, aout, aoe} = $random(seed);
    apb(1'b1, GPIO_OUT_OFS, {24'h0, gout});
    apb(1'b1, GPIO_OE_OFS, {24'h0, goe});
    apb(1'b1, AGPIO_OUT_OFS, {24'h0, aout});
    apb(1'b1, AGPIO_OE_OFS, {24'h0, aoe});
  endtask : shake
  // Compare every pad against the matrix model
  task automatic check_pads();
    byte  c;
    logic drv, val;
    repeat (3) @(posedge clk);
    @(negedge clk);
    for (int p = 0; p < NPAD; p++)
    begin
      c = tbl[p][sel[p]];
      drv = 1'b1;
      val = 1'bx;
      if (c == ".")
        drv = 1'b0;
      else if (c >= "a")
        val = core[c - "a"];
      else if (c == "S" || c == "K")
      begin
        drv = core.pcm_master;
        val = core[(c == "S") ? 14 : 13];
      end
      else if (c >= "A")
      begin
        drv = aoe[c - "A"];
        val = aout[c - "A"];
      end
      else
      begin
        drv = goe[c - "0"];
        val = gout[c - "0"];
      end
      cmp_bit(pad_oe_n[p], ~drv, p);
      if (drv)
        cmp_bit(pad_o[p], val, p);
    end
    cmp_bit(coex, core.coex_activity, 99);
    cmp_bit(core_in.coex_transmit_grant,
      (sel[P_SDI] == 7) ? pad_i[P_SDI] : 1'b0, P_SDI);
  endtask : check_pads
  // Input bits seen by software, ORed over the pads that carry them
  task automatic check_in();
    logic [7:0] g, a;
    byte        c;
    g = '0;
    a = '0;
    for (int p = 0; p < NPAD; p++)
    begin
      c = tbl[p][sel[p]];
      if (c >= "0" && c <= "7")
        g[c - "0"] |= pad_i[p];
      else if (c >= "A" && c <= "H")
        a[c - "A"] |= pad_i[p];
    end
    apb(1'b0, GPIO_IN_OFS, 32'h0);
    cmp_word({24'h0, rd[7:0]}, {24'h0, g});
    apb(1'b0, AGPIO_IN_OFS, 32'h0);
    cmp_word({24'h0, rd[7:0]}, {24'h0, a});
  endtask : check_in
  // Main sequence
  initial
  begin
    seed = 32'h61E6;
    mismatches = 0;
    n_compared = 0;
    {rst_n, psel, pen, pwr, paddr, pwdata} = '0;
    {core, ext, gout, goe, aout, aoe} = '0;
    foreach (sel[p]) sel[p] = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    check_pads();
    // Every setting on all pads together
    for (int s = 0; s < 8; s++)
    begin
      foreach (sel[p]) sel[p] = s;
      put_sel();
      repeat (3)
      begin
        shake();
        check_pads();
        check_in();
      end
    end
    // Independent per-pad settings
    repeat (25)
    begin
      foreach (sel[p]) sel[p] = $unsigned($random(seed)) % 8;
      put_sel();
      shake();
      check_pads();
      check_in();
    end
    // Unmapped places answer with an error and read zero
    apb(1'b0, 8'h24, 32'h0);
    cmp_word({31'h0, err}, 32'h1);
    cmp_word(rd, 32'h0);
    apb(1'b1, 8'h3C, 32'hFFFFFFFF);
    cmp_word({31'h0, err}, 32'h1);
    // Reset in mid-run returns every pad to setting zero
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (sel[p]) sel[p] = 0;
    {gout, goe, aout, aoe} = '0;
    check_pads();
    apb(1'b0, SEL_HI_OFS, 32'h0);
    cmp_word(rd, 32'h0);
    tally_and_finish();
  end
endmodule : btpm_mux_bench
`default_nettype wire
